//--- rtl/qdf_consts.svh
`ifndef QDF_CONSTS_SVH
`define QDF_CONSTS_SVH

// ----------------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------------
`define QDF_CLK_PS           4000
`define QDF_SCG_FILT_US      140
`define QDF_SCG_FILT_CYC     ((`QDF_SCG_FILT_US * 1000000 + `QDF_CLK_PS - 1) / `QDF_CLK_PS)
`define QDF_OL_FILT_US       140
`define QDF_OL_FILT_CYC      ((`QDF_OL_FILT_US * 1000000 + `QDF_CLK_PS - 1) / `QDF_CLK_PS)
`define QDF_SHORT_DELAY_NS   200
`define QDF_SHORT_DELAY_CYC  ((`QDF_SHORT_DELAY_NS * 1000 + `QDF_CLK_PS - 1) / `QDF_CLK_PS)
`define QDF_SEL_FILT_NS      20
`define QDF_SEL_FILT_CYC     ((`QDF_SEL_FILT_NS * 1000 + `QDF_CLK_PS - 1) / `QDF_CLK_PS)

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define QDF_ADDR_W           8
`define QDF_CTRL_OFS         8'h00
`define QDF_STATUS_OFS       8'h04
`define QDF_FAULT_OFS        8'h08
`define QDF_CTRL_REC_EN_BIT  0
`define QDF_CTRL_FORCE_BIT   1
`define QDF_CTRL_RST         2'h1
`define QDF_STAT_HOLD_BIT    8
`define QDF_STAT_SEL_BIT     9
`define QDF_FAULT_ANY_BIT    8

// ----------------------------------------------------------------------------
// Serial frame and synchroniser reset values
// ----------------------------------------------------------------------------
`define QDF_FRAME_W          9
`define QDF_SYNC_W           25
`define QDF_SYNC_RST         25'h1E00004

`endif

//--- rtl/qdf_pkg.sv
package qdf_pkg;

  // --------------------------------------------------------------------------
  // Types shared by the block and its bench.
  // --------------------------------------------------------------------------

  // Per-channel comparator levels from the analog front end, bit n is channel n.
  typedef struct packed {
    logic [3:0] overcurrent;  // Current above the short limit.
    logic [3:0] overtemp;     // Junction above the shutdown threshold.
    logic [3:0] low_current;  // Current below the open-load reference.
    logic [3:0] drain_low;    // Drain below the short-to-ground reference.
  } qdf_sense_t;

  // Two-bit fault code per channel; the numeric order is the priority.
  typedef enum logic [1:0] {
    FLT_NONE            = 2'h0,
    FLT_OPEN_LOAD       = 2'h1,
    FLT_SHORT_GROUND    = 2'h2,
    FLT_SHORT_BATTERY   = 2'h3
  } qdf_fault_t;

  // Serial engine states, Gray coded along idle, first bit, shifting.
  typedef enum logic [1:0] {
    SER_IDLE  = 2'h0,
    SER_FIRST = 2'h1,
    SER_SHIFT = 2'h3
  } qdf_ser_state_t;

endpackage

//--- rtl/qdf_top.sv
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`include "qdf_consts.svh"

module qdf_top #(
  parameter int unsigned SCG_FILT_CYC = `QDF_SCG_FILT_CYC, // Short-to-ground filter cycles.
  parameter int unsigned OL_FILT_CYC  = `QDF_OL_FILT_CYC   // Open-load filter cycles.
) (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    pclk_en,
  input  wire logic [`QDF_ADDR_W-1:0]  paddr,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic [3:0]              channel_on_n,
  input  wire qdf_pkg::qdf_sense_t     sense,
  input  wire logic                    supply_low,
  input  wire logic                    reset_in_n,
  input  wire logic                    serial_select_n,
  input  wire logic                    serial_clk,
  input  wire logic                    serial_din,
  output logic                         serial_dout,
  output logic                         serial_dout_oe,
  output logic      [3:0]              stage_on
);
  import qdf_pkg::*;

  // --------------------------------------------------------------------------
  // Constants derived from the timing figures
  // --------------------------------------------------------------------------

  // Last count value of each qualification counter.
  localparam logic [15:0] SCG_LIM = 16'(SCG_FILT_CYC - 1);
  localparam logic [15:0] OL_LIM  = 16'(OL_FILT_CYC - 1);
  localparam logic [7:0]  OC_LIM  = 8'(`QDF_SHORT_DELAY_CYC - 1);
  localparam logic [2:0]  SEL_LIM = 3'(`QDF_SEL_FILT_CYC);

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------

  logic [`QDF_SYNC_W-1:0] sync1_ff;      // First stage of every pin synchroniser.
  logic [`QDF_SYNC_W-1:0] sync2_ff;      // Second stage, the only one logic reads.
  logic [3:0]             on_cmd;        // Channel commanded on (input low).
  qdf_sense_t             sns;           // Synchronised comparator levels.
  logic                   rst_hold;      // Pin reset or undervoltage active.
  logic                   sel_sync;      // Synchronised select level.
  logic                   sck_sync;      // Synchronised serial clock level.
  logic                   din_sync;      // Synchronised serial data in.
  logic                   sck_d_ff;      // Serial clock one cycle back, for edges.
  logic                   sck_rise;      // Serial clock rising edge seen.
  logic                   sck_fall;      // Serial clock falling edge seen.
  logic [2:0]             sel_cnt_ff;    // Select glitch filter counter.
  logic                   sel_filt_ff;   // Filtered select level.
  logic                   sel_fall;      // Filtered select went active.
  logic                   sel_rise;      // Filtered select went inactive.
  qdf_ser_state_t         ser_ff;        // Serial engine state.
  qdf_ser_state_t         nxt_ser;       // Next serial engine state.
  logic [`QDF_FRAME_W-1:0] shift_ff;     // Diagnostic shift register.
  logic                   dout_ff;       // Serial data output level.
  logic                   dout_oe_ff;    // Serial data output enable.
  logic                   store_clr;     // Fault store clear pulse.
  logic [7:0]             store_ff;      // Fault byte, two bits per channel.
  logic                   any_fault;     // At least one code is stored.
  logic [1:0]             ctrl_ff;       // Control register.
  logic [3:0]             stage_ff;      // Power stage gate drive.
  logic [3:0]             latched_ff;    // Protective shutdown latch per channel.
  logic [3:0]             trip;          // Qualified overcurrent or overtemperature.
  logic [3:0]             scb_evt;       // Short-to-battery event.
  logic [3:0]             scg_evt;       // Short-to-ground event.
  logic [3:0]             ol_evt;        // Open-load event.
  logic [7:0]             oc_cnt_ff [4]; // Overcurrent persistence counters.
  logic [15:0]            scg_cnt_ff [4];// Short-to-ground filter counters.
  logic [15:0]            ol_cnt_ff [4]; // Open-load filter counters.
  logic [31:0]            prdata_ff;     // Read data register.
  logic                   pready_ff;     // Ready register.
  logic                   pslverr_ff;    // Error register.
  logic [31:0]            rd_word;       // Read data selected by address.
  logic                   addr_ok;       // Address hits a mapped register.

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------

  // All asynchronous pins pass two flops; idle values keep stages off and
  // the device in reset until the pins are seen.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_ff <= `QDF_SYNC_RST;
      sync2_ff <= `QDF_SYNC_RST;
    end else if (pclk_en) begin
      sync1_ff <= {channel_on_n, sense, supply_low, reset_in_n,
                   serial_select_n, serial_clk, serial_din};
      sync2_ff <= sync1_ff;
    end
  end

  // Slices of the second synchroniser stage.
  assign on_cmd   = ~sync2_ff[24:21];
  assign sns      = qdf_sense_t'(sync2_ff[20:5]);
  assign rst_hold = sync2_ff[4] | ~sync2_ff[3];
  assign sel_sync = sync2_ff[2];
  assign sck_sync = sync2_ff[1];
  assign din_sync = sync2_ff[0];

  // --------------------------------------------------------------------------
  // Serial clock edges and select filter
  // --------------------------------------------------------------------------

  // Keeps the previous clock level so its edges can be found.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_d_ff <= 1'b0;
    end else if (pclk_en) begin
      sck_d_ff <= sck_sync;
    end
  end

  assign sck_rise = sck_sync & ~sck_d_ff;
  assign sck_fall = ~sck_sync & sck_d_ff;

  // The filtered select follows the pin only after it has differed for the
  // whole filter time, so a short spike never turns the output driver on.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_cnt_ff  <= 3'h0;
      sel_filt_ff <= 1'b1;
    end else if (pclk_en) begin
      if (sel_sync == sel_filt_ff) begin
        sel_cnt_ff <= 3'h0;
      end else if (sel_cnt_ff == SEL_LIM) begin
        sel_cnt_ff  <= 3'h0;
        sel_filt_ff <= sel_sync;
      end else begin
        sel_cnt_ff <= sel_cnt_ff + 3'h1;
      end
    end
  end

  // Filtered select edges, one cycle wide.
  assign sel_fall = sel_filt_ff & ~sel_sync & (sel_cnt_ff == SEL_LIM);
  assign sel_rise = ~sel_filt_ff & sel_sync & (sel_cnt_ff == SEL_LIM);

  // --------------------------------------------------------------------------
  // Serial engine
  // --------------------------------------------------------------------------

  // Next state: a frame opens on select active and closes on select
  // inactive; the first clock rise moves from the first bit to shifting.
  always_comb begin
    nxt_ser = ser_ff;
    case (ser_ff)
      SER_IDLE: begin
        if (sel_fall) begin
          nxt_ser = SER_FIRST;
        end
      end
      SER_FIRST: begin
        if (sel_rise) begin
          nxt_ser = SER_IDLE;
        end else if (sck_rise) begin
          nxt_ser = SER_SHIFT;
        end
      end
      SER_SHIFT: begin
        if (sel_rise) begin
          nxt_ser = SER_IDLE;
        end
      end
      default: begin
        nxt_ser = SER_IDLE;
      end
    endcase
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ser_ff <= SER_IDLE;
    end else if (pclk_en) begin
      ser_ff <= nxt_ser;
    end
  end

  // Clear pulse on the first rise, after the frame was already loaded.
  assign store_clr = (ser_ff == SER_FIRST) & sck_rise & ~sel_rise;

  assign any_fault = |store_ff;

  // Shift register: load on select active, shift out on rise, capture in on
  // fall. Captured bits pass through this register and reach the output from the ninth rise.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_ff <= '0;
    end else if (pclk_en) begin
      if (ser_ff == SER_IDLE) begin
        if (sel_fall) begin
          shift_ff <= {any_fault, store_ff};
        end
      end else if (sck_rise) begin
        shift_ff <= {shift_ff[`QDF_FRAME_W-2:0], 1'b0};
      end else if (sck_fall) begin
        shift_ff[0] <= din_sync;
      end
    end
  end

  // Output pin level and driver enable; released outside a frame.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dout_ff    <= 1'b0;
      dout_oe_ff <= 1'b0;
    end else if (pclk_en) begin
      dout_oe_ff <= (nxt_ser != SER_IDLE);
      if (nxt_ser == SER_IDLE) begin
        dout_ff <= 1'b0;
      end else if (ser_ff == SER_IDLE) begin
        dout_ff <= any_fault;
      end else if (sck_rise) begin
        dout_ff <= shift_ff[`QDF_FRAME_W-2];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Per-channel protection and fault qualification
  // --------------------------------------------------------------------------

  for (genvar ch = 0; ch < 4; ch++) begin : g_ch

    // Overcurrent must persist for the short delay while the stage is on.
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        oc_cnt_ff[ch] <= 8'h0;
      end else if (pclk_en) begin
        if (!(sns.overcurrent[ch] && stage_ff[ch])) begin
          oc_cnt_ff[ch] <= 8'h0;
        end else if (oc_cnt_ff[ch] != OC_LIM) begin
          oc_cnt_ff[ch] <= oc_cnt_ff[ch] + 8'h1;
        end
      end
    end

    // Trip on qualified overcurrent or on this channel's overtemperature.
    assign trip[ch] = (sns.overcurrent[ch] & stage_ff[ch] & (oc_cnt_ff[ch] == OC_LIM))
                    | sns.overtemp[ch];
    assign scb_evt[ch] = trip[ch];

    // Open-load filter runs only while the stage is on; a shorter on-time
    // restarts it and records nothing.
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ol_cnt_ff[ch] <= 16'h0;
      end else if (pclk_en) begin
        if (!(sns.low_current[ch] && stage_ff[ch])) begin
          ol_cnt_ff[ch] <= 16'h0;
        end else if (ol_cnt_ff[ch] != OL_LIM) begin
          ol_cnt_ff[ch] <= ol_cnt_ff[ch] + 16'h1;
        end
      end
    end

    assign ol_evt[ch] = sns.low_current[ch] & stage_ff[ch] & (ol_cnt_ff[ch] == OL_LIM);

    // Short-to-ground filter runs only while the channel is commanded off.
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        scg_cnt_ff[ch] <= 16'h0;
      end else if (pclk_en) begin
        if (!(sns.drain_low[ch] && !on_cmd[ch])) begin
          scg_cnt_ff[ch] <= 16'h0;
        end else if (scg_cnt_ff[ch] != SCG_LIM) begin
          scg_cnt_ff[ch] <= scg_cnt_ff[ch] + 16'h1;
        end
      end
    end

    assign scg_evt[ch] = sns.drain_low[ch] & ~on_cmd[ch] & (scg_cnt_ff[ch] == SCG_LIM);

    // Shutdown latch: set by a trip, cleared by pin reset or undervoltage, or while the input is off and no trip is present.
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        latched_ff[ch] <= 1'b0;
      end else if (pclk_en) begin
        if (rst_hold) begin
          latched_ff[ch] <= 1'b0;
        end else if (trip[ch]) begin
          latched_ff[ch] <= 1'b1;
        end else if (!on_cmd[ch]) begin
          latched_ff[ch] <= 1'b0;
        end
      end
    end

    // Gate drive follows the input unless tripped, latched, reset or forced off.
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        stage_ff[ch] <= 1'b0;
      end else if (pclk_en) begin
        stage_ff[ch] <= on_cmd[ch] & ~latched_ff[ch] & ~trip[ch] & ~rst_hold
                      & ~ctrl_ff[`QDF_CTRL_FORCE_BIT];
      end
    end

    // Fault code keeps the highest priority seen since the last clear; an
    // event in the clear cycle survives the clear.
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        store_ff[2*ch+1:2*ch] <= FLT_NONE;
      end else if (pclk_en) begin
        if (rst_hold) begin
          store_ff[2*ch+1:2*ch] <= FLT_NONE;
        end else begin
          logic [1:0] evt;
          evt = FLT_NONE;
          if (ctrl_ff[`QDF_CTRL_REC_EN_BIT]) begin
            if (scb_evt[ch]) begin
              evt = FLT_SHORT_BATTERY;
            end else if (scg_evt[ch]) begin
              evt = FLT_SHORT_GROUND;
            end else if (ol_evt[ch]) begin
              evt = FLT_OPEN_LOAD;
            end
          end
          if (store_clr) begin
            store_ff[2*ch+1:2*ch] <= evt;
          end else if (evt > store_ff[2*ch+1:2*ch]) begin
            store_ff[2*ch+1:2*ch] <= evt;
          end
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // APB slave
  // --------------------------------------------------------------------------

  // Read multiplexer; unmapped addresses read zero with an error.
  always_comb begin
    rd_word = 32'h0;
    addr_ok = 1'b1;
    case (paddr)
      `QDF_CTRL_OFS: begin
        rd_word[1:0] = ctrl_ff;
      end
      `QDF_STATUS_OFS: begin
        rd_word[3:0]                 = stage_ff;
        rd_word[7:4]                 = latched_ff;
        rd_word[`QDF_STAT_HOLD_BIT] = rst_hold;
        rd_word[`QDF_STAT_SEL_BIT]  = (ser_ff != SER_IDLE);
      end
      `QDF_FAULT_OFS: begin
        rd_word[7:0]                 = store_ff;
        rd_word[`QDF_FAULT_ANY_BIT] = any_fault;
      end
      default: begin
        addr_ok = 1'b0;
      end
    endcase
  end

  // Answer one cycle into the access phase; data and error are captured in
  // the setup cycle so every bus output comes from a flop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      prdata_ff  <= 32'h0;
      pslverr_ff <= 1'b0;
    end else if (pclk_en) begin
      pready_ff  <= psel & ~penable;
      if (psel && !penable) begin
        prdata_ff  <= pwrite ? 32'h0 : rd_word;
        pslverr_ff <= ~addr_ok;
      end else begin
        prdata_ff  <= 32'h0;
        pslverr_ff <= 1'b0;
      end
    end
  end

  // Control register takes a write at the completing edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= `QDF_CTRL_RST;
    end else if (pclk_en) begin
      if (psel && penable && pready_ff && pwrite && (paddr == `QDF_CTRL_OFS)) begin
        ctrl_ff <= pwdata[1:0];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------

  assign prdata         = prdata_ff;
  assign pready         = pready_ff;
  assign pslverr        = pslverr_ff;
  assign serial_dout    = dout_ff;
  assign serial_dout_oe = dout_oe_ff;
  assign stage_on       = stage_ff;

endmodule

//--- test/qdf_mcu_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Microcontroller side of the diagnostic link, acting as SPI master.
// ----------------------------------------------------------------------------
module qdf_mcu_model (
  input  wire logic pclk,
  output logic      serial_select_n,
  output logic      serial_clk,
  output logic      serial_din,
  input  wire logic serial_dout,
  input  wire logic serial_dout_oe
);
  // Idle state: deselected, clock parked low.
  initial begin
    serial_select_n = 1'b1;
    serial_clk      = 1'b0;
    serial_din      = 1'b0;
  end
  // One frame: flag, then eight bits; a released output reads as unknown.
  task frame(input logic [7:0] tx, output logic [8:0] rx);
    int i;
    @(posedge pclk) serial_select_n <= 1'b0;
    repeat (16) @(posedge pclk);
    for (i = 8; i >= 0; i--) begin
      @(negedge pclk) rx[i] = serial_dout_oe ? serial_dout : 1'bx;
      if (i > 0) begin
        @(posedge pclk) serial_clk <= 1'b1;
        serial_din <= tx[i-1];
        repeat (4) @(posedge pclk);
        serial_clk <= 1'b0;
        repeat (3) @(posedge pclk);
      end
    end
    repeat (4) @(posedge pclk);
    serial_select_n <= 1'b1;
    repeat (16) @(posedge pclk);
  endtask
  // A short select pulse with the clock held low.
  task glitch(input int n);
    @(posedge pclk) serial_select_n <= 1'b0;
    repeat (n) @(posedge pclk);
    serial_select_n <= 1'b1;
  endtask
endmodule

//--- test/qdf_top_asserts.sv
`timescale 1ns/1ps
`include "qdf_consts.svh"
// ----------------------------------------------------------------------------
// Port checks of the quad driver.
// ----------------------------------------------------------------------------
module qdf_chk #(
  parameter int unsigned SCG_FILT_CYC = 20,
  parameter int unsigned OL_FILT_CYC  = 20
) (
  input wire logic                pclk,
  input wire logic                presetn,
  input wire logic [7:0]          paddr,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pready,
  input wire logic                pslverr,
  input wire logic [3:0]          channel_on_n,
  input wire qdf_pkg::qdf_sense_t sense,
  input wire logic                supply_low,
  input wire logic                reset_in_n,
  input wire logic                serial_select_n,
  input wire logic                serial_clk,
  input wire logic                serial_dout,
  input wire logic                serial_dout_oe,
  input wire logic [3:0]          stage_on
);
  import qdf_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_apb_answer: assert property (psel && !penable |=> pready && penable)
    else $error("pready missing after setup");
  a_apb_single: assert property (pready |=> !pready) else $error("pready held");
  a_unmapped_err: assert property (psel && !penable && !(paddr inside {`QDF_CTRL_OFS,
    `QDF_STATUS_OFS, `QDF_FAULT_OFS}) |=> pslverr) else $error("no error on unmapped");
  a_stage_follow: assert property ((stage_on & $past(channel_on_n, 3)) == 4'h0)
    else $error("stage on with input off");
  a_temp_trip: assert property ((stage_on & $past(sense.overtemp, 3)) == 4'h0)
    else $error("stage on after overtemperature");
  a_hold_reset: assert property ((supply_low || !reset_in_n) [*3] |=> stage_on == 4'h0)
    else $error("stage on during reset");
  a_dout_idle: assert property (!serial_dout_oe |-> !serial_dout)
    else $error("data out while released");
  a_select_release: assert property (serial_select_n [*8] |=> ##3 !serial_dout_oe)
    else $error("output driven while deselected");
  a_glitch_quiet: assert property ($rose(serial_dout_oe) |->
    !$past(serial_select_n, 3) && !$past(serial_select_n, 7)) else $error("select glitch drove");
  a_dout_shift: assert property (serial_dout_oe && $past(serial_dout_oe) && $changed(serial_dout)
    |-> $past(serial_clk, 2) || $past(serial_clk, 3) || $past(serial_clk, 4))
    else $error("data out moved without clock rise");
  c_frame: cover property ($rose(serial_dout_oe));
  c_trip: cover property ($fell(stage_on[2]));
  c_error: cover property (pready && pslverr);
endmodule

bind qdf_top qdf_chk #(.SCG_FILT_CYC(SCG_FILT_CYC), .OL_FILT_CYC(OL_FILT_CYC)) qdf_chk_i (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .channel_on_n(channel_on_n), .sense(sense),
  .supply_low(supply_low), .reset_in_n(reset_in_n), .serial_select_n(serial_select_n),
  .serial_clk(serial_clk), .serial_dout(serial_dout), .serial_dout_oe(serial_dout_oe),
  .stage_on(stage_on));

//--- test/qdf_top_test.sv
`timescale 1ns/1ps
`include "qdf_consts.svh"
module qdf_top_test;
  import qdf_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic        supply_low, reset_in_n, serial_select_n, serial_clk, serial_din;
  logic        serial_dout, serial_dout_oe;
  logic        pclk_en = 1'b1;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  channel_on_n, stage_on;
  logic [8:0]  rx;
  qdf_sense_t  sense;
  int          mismatches = 0;
  int          num_checks = 0;
  qdf_top #(.SCG_FILT_CYC(20), .OL_FILT_CYC(20)) qdf_top_i (
    .pclk(pclk), .presetn(presetn), .pclk_en(pclk_en), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .channel_on_n(channel_on_n), .sense(sense), .supply_low(supply_low),
    .reset_in_n(reset_in_n), .serial_select_n(serial_select_n), .serial_clk(serial_clk),
    .serial_din(serial_din), .serial_dout(serial_dout), .serial_dout_oe(serial_dout_oe),
    .stage_on(stage_on));
  qdf_mcu_model qdf_mcu_model_i (
    .pclk(pclk), .serial_select_n(serial_select_n), .serial_clk(serial_clk),
    .serial_din(serial_din), .serial_dout(serial_dout), .serial_dout_oe(serial_dout_oe));
  // Free-running 250 MHz clock.
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // Compares one value and counts the result.
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // One APB transfer; waits for pready, only the watchdog ends a hang.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk) penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, supply_low} = '0;
    {reset_in_n, channel_on_n, sense} = {5'h1F, 16'h0};
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, `QDF_CTRL_OFS, 0); chk("ctrl reset", 32'h1, rd);
    apb(0, 8'h0C, 0); chk("unmapped", 32'h1, {31'h0, er}); chk("unmapped data", 0, rd);
    apb(1, `QDF_FAULT_OFS, 32'hFF); chk("ro write", 0, {31'h0, er});
    @(posedge pclk) channel_on_n <= 4'hA;
    repeat (6) @(posedge pclk);
    chk("stages", 32'h5, {28'h0, stage_on});
    sense.low_current <= 4'h1; sense.drain_low <= 4'hA;
    repeat (10) @(posedge pclk); sense.drain_low <= 4'h2;
    repeat (25) @(posedge pclk); sense <= '0;
    apb(0, `QDF_FAULT_OFS, 0); chk("fault ol scg", 32'h109, rd);
    @(posedge pclk) sense <= {4'h1, 4'h4, 8'h0};
    @(posedge pclk) sense.overtemp <= 4'h0;
    repeat (60) @(posedge pclk); sense <= '0;
    repeat (5) @(posedge pclk);
    chk("tripped", 0, {28'h0, stage_on});
    apb(0, `QDF_STATUS_OFS, 0); chk("status", 32'h50, rd);
    apb(0, `QDF_FAULT_OFS, 0); chk("fault scb", 32'h13B, rd);
    @(posedge pclk) channel_on_n <= 4'hF;
    repeat (6) @(posedge pclk); channel_on_n <= 4'hA;
    repeat (6) @(posedge pclk);
    chk("retoggled", 32'h5, {28'h0, stage_on});
    qdf_mcu_model_i.frame(8'hFF, rx); chk("frame", 32'h13B, {23'h0, rx});
    apb(0, `QDF_FAULT_OFS, 0); chk("cleared", 0, rd);
    chk("din no effect", 32'h5, {28'h0, stage_on});
    qdf_mcu_model_i.frame(8'h00, rx); chk("empty frame", 0, {23'h0, rx});
    qdf_mcu_model_i.glitch(3);
    repeat (12) begin
      @(negedge pclk) chk("glitch oe", 0, {31'h0, serial_dout_oe});
    end
    for (int k = 0; k < 2; k++) begin
      @(posedge pclk) sense.drain_low <= 4'h2;
      repeat (30) @(posedge pclk);
      {sense.drain_low, supply_low, reset_in_n} <= {4'h0, k == 0, k == 0};
      repeat (6) @(posedge pclk);
      chk("reset stages", 0, {28'h0, stage_on});
      apb(0, `QDF_FAULT_OFS, 0); chk("reset store", 0, rd);
      @(posedge pclk) {supply_low, reset_in_n} <= 2'b01;
    end
    apb(1, `QDF_CTRL_OFS, 32'h2); apb(0, `QDF_CTRL_OFS, 0); chk("ctrl write", 32'h2, rd);
    @(posedge pclk) sense.drain_low <= 4'h2;
    repeat (30) @(posedge pclk); sense.drain_low <= 4'h0;
    chk("forced off", 0, {28'h0, stage_on});
    apb(0, `QDF_FAULT_OFS, 0); chk("record off", 0, rd);
    finish_test;
  end
  // Cuts a hung run short.
  initial begin
    #40000;
    mismatches++;
    finish_test;
  end
endmodule
